// >>> include/uisr_params.svh
// constants of the unique-number and parameter-table read logic
// How it works
// - a 128-bit per-part number is fixed at build time; no command can change it.
// - after those dummy bytes the 128 number bits go out, changing on falling edges.
// - table read is 5AH, three address bytes, one dummy byte; inputs sampled on rising edges.
// - after the dummy byte table bytes shift out, changing on falling clock edges.
// - any table byte may be the starting address, no alignment needed.
// - the table address advances by one after every output byte.
// - past the highest address the counter wraps to zero and streaming goes on.
// - select rising ends the table read at any time; output stops being driven.
// - a table read during erase, program or status write is ignored.
// - bytes 0-3 give the signature low byte first; byte 4 minor 00H, 5 major 01H.
// - byte 6 gives 01H, meaning two parameter headers follow.
// - header one bytes 8-B: id 00H, minor 00H, major 01H, length 09H.
// - header one bytes C-E give pointer 000030H, low byte first.
// - header two bytes 10-13: vendor id, minor 00H, major 01H, length 03H.
// - header two bytes 14-16 give pointer 000060H, low byte first.
// - bytes 07H, 0FH and 17H always read FFH and cannot change.
// - select high returns to standby; next command waits for a fresh selection.
`ifndef UISR_PARAMS_SVH
`define UISR_PARAMS_SVH

// ************************************************************
// command codes, phase lengths in clock bits, number length in bytes and idle fill level
// ************************************************************
`define UISR_OP_UNIQUE_NUMBER_READ 8'h4B
`define UISR_OP_PARAM_TABLE_READ   8'h5A
`define UISR_CMD_BITS              6'h08
`define UISR_ADDR_BITS             6'h18
`define UISR_TBL_DUMMY_BITS        6'h08
`define UISR_UID_DUMMY_BITS        6'h20
`define UISR_UID_BYTES             8'h10
`define UISR_IDLE_FILL             1'h1

// ************************************************************
// table byte locations
// ************************************************************
`define UISR_A_SIG0      8'h00
`define UISR_A_SIG1      8'h01
`define UISR_A_SIG2      8'h02
`define UISR_A_SIG3      8'h03
`define UISR_A_MINOR     8'h04
`define UISR_A_MAJOR     8'h05
`define UISR_A_NHDR      8'h06
`define UISR_A_UNUSED0   8'h07
`define UISR_A_H1_ID     8'h08
`define UISR_A_H1_MINOR  8'h09
`define UISR_A_H1_MAJOR  8'h0A
`define UISR_A_H1_LEN    8'h0B
`define UISR_A_H1_PTR0   8'h0C
`define UISR_A_H1_PTR1   8'h0D
`define UISR_A_H1_PTR2   8'h0E
`define UISR_A_UNUSED1   8'h0F
`define UISR_A_H2_ID     8'h10
`define UISR_A_H2_MINOR  8'h11
`define UISR_A_H2_MAJOR  8'h12
`define UISR_A_H2_LEN    8'h13
`define UISR_A_H2_PTR0   8'h14
`define UISR_A_H2_PTR1   8'h15
`define UISR_A_H2_PTR2   8'h16
`define UISR_A_UNUSED2   8'h17

// ************************************************************
// table byte values
// ************************************************************
`define UISR_V_SIG0      8'h53
`define UISR_V_SIG1      8'h46
`define UISR_V_SIG2      8'h44
`define UISR_V_SIG3      8'h50
`define UISR_V_MINOR     8'h00
`define UISR_V_MAJOR     8'h01
`define UISR_V_NHDR      8'h01
`define UISR_V_STD_ID    8'h00
`define UISR_V_H1_LEN    8'h09
`define UISR_V_H1_PTR    24'h000030
`define UISR_V_H2_LEN    8'h03
`define UISR_V_H2_PTR    24'h000060
`define UISR_V_UNUSED    8'hFF

`endif

// >>> include/uisr_pkg.sv
// types shared by the unique-number and parameter-table read logic
`default_nettype none
package uisr_pkg;
   typedef enum logic [2:0] {
      UISR_ST_CMD    = 3'h0,
      UISR_ST_ADDR   = 3'h1,
      UISR_ST_DUMMY  = 3'h3,
      UISR_ST_DATA   = 3'h2,
      UISR_ST_IGNORE = 3'h6
   } uisr_state_t;

   typedef enum logic {
      UISR_MODE_TABLE = 1'h0,
      UISR_MODE_UID   = 1'h1
   } uisr_mode_t;
endpackage
`default_nettype wire

// >>> hw/uisr_fifo.sv
// small flop-based fifo with valid/ready on both sides and flush
`timescale 1ns/1ns
`default_nettype none
module uisr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             flush_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("uisr_fifo: DEPTH must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_ptr_q;
   logic [AW:0]      rd_ptr_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (wr_ptr_q ^ rd_ptr_q) != {1'h1, {AW{1'h0}}};
   assign out_valid_o = wr_ptr_q != rd_ptr_q;
   assign out_data_o  = mem_q[rd_ptr_q[AW-1:0]];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'h1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'h1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
      end
   end
endmodule // uisr_fifo
`default_nettype wire

// >>> hw/uisr_rom.sv
// read-only parameter table with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "uisr_params.svh"
module uisr_rom #(
   parameter int          AW        = 7,
   parameter logic [7:0]  VENDOR_ID = 8'h5C
) (
   // clock and reset
   input  wire logic          sys_clk_i,
   input  wire logic          rst_i,
   // read port
   input  wire logic          rd_en_i,
   input  wire logic [AW-1:0] rd_addr_i,
   output logic      [7:0]    rd_data_o
);
   initial begin
      if (AW < 5 || AW > 8) begin
         $error("uisr_rom: AW must lie between 5 and 8");
      end
   end

   logic [7:0] addr;
   logic [7:0] rom_byte;
   localparam logic [23:0] PTR1 = `UISR_V_H1_PTR;
   localparam logic [23:0] PTR2 = `UISR_V_H2_PTR;

   assign addr = 8'(rd_addr_i);

   // ************************************************************
   // table contents, fixed in logic so nothing can alter them
   // ************************************************************
   always_comb begin
      unique case (addr)
         `UISR_A_SIG0:     rom_byte = `UISR_V_SIG0;
         `UISR_A_SIG1:     rom_byte = `UISR_V_SIG1;
         `UISR_A_SIG2:     rom_byte = `UISR_V_SIG2;
         `UISR_A_SIG3:     rom_byte = `UISR_V_SIG3;
         `UISR_A_MINOR:    rom_byte = `UISR_V_MINOR;
         `UISR_A_MAJOR:    rom_byte = `UISR_V_MAJOR;
         `UISR_A_NHDR:     rom_byte = `UISR_V_NHDR;
         `UISR_A_H1_ID:    rom_byte = `UISR_V_STD_ID;
         `UISR_A_H1_MINOR: rom_byte = `UISR_V_MINOR;
         `UISR_A_H1_MAJOR: rom_byte = `UISR_V_MAJOR;
         `UISR_A_H1_LEN:   rom_byte = `UISR_V_H1_LEN;
         `UISR_A_H1_PTR0:  rom_byte = PTR1[7:0];
         `UISR_A_H1_PTR1:  rom_byte = PTR1[15:8];
         `UISR_A_H1_PTR2:  rom_byte = PTR1[23:16];
         `UISR_A_H2_ID:    rom_byte = VENDOR_ID;
         `UISR_A_H2_MINOR: rom_byte = `UISR_V_MINOR;
         `UISR_A_H2_MAJOR: rom_byte = `UISR_V_MAJOR;
         `UISR_A_H2_LEN:   rom_byte = `UISR_V_H2_LEN;
         `UISR_A_H2_PTR0:  rom_byte = PTR2[7:0];
         `UISR_A_H2_PTR1:  rom_byte = PTR2[15:8];
         `UISR_A_H2_PTR2:  rom_byte = PTR2[23:16];
         default:          rom_byte = `UISR_V_UNUSED;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rd_data_o <= `UISR_V_UNUSED;
      end else if (rd_en_i) begin
         rd_data_o <= rom_byte;
      end
   end

   AST_ROM_SIGNATURE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_en_i && addr == `UISR_A_SIG3 |=> rd_data_o == `UISR_V_SIG3)
      else $error("signature top byte wrong");
   AST_ROM_HDR_COUNT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_en_i && addr == `UISR_A_NHDR |=> rd_data_o == `UISR_V_NHDR)
      else $error("header count wrong");
   AST_ROM_UNUSED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_en_i && (addr == `UISR_A_UNUSED0 || addr == `UISR_A_UNUSED1 || addr == `UISR_A_UNUSED2)
      |=> rd_data_o == `UISR_V_UNUSED)
      else $error("unused header byte not FFH");
   AST_ROM_PTR1: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_en_i && addr == `UISR_A_H1_PTR0 |=> rd_data_o == PTR1[7:0])
      else $error("first pointer low byte wrong");
endmodule // uisr_rom
`default_nettype wire

// >>> hw/uisr_top.sv
// serial front end serving the unique-number read and the parameter-table read
`timescale 1ns/1ns
`default_nettype none
`include "uisr_params.svh"
module uisr_top #(
   parameter int             TBL_AW     = 7,
   parameter int             FIFO_DEPTH = 8,
   // arbitrary values, stand-ins for the factory content
   parameter logic [127:0]   UNIQUE_ID  = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
   parameter logic [7:0]     VENDOR_ID  = 8'h5C
) (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // serial pins from the host
   input  wire logic cs_n_i,
   input  wire logic sclk_i,
   input  wire logic si_i,
   // serial output pin
   output logic      so_o,
   output logic      so_oe_o,
   // array status from the rest of the device
   input  wire logic busy_i
);
   initial begin
      if (TBL_AW < 5 || TBL_AW > 8 || FIFO_DEPTH < 2) begin
         $error("uisr_top: TBL_AW must lie between 5 and 8, FIFO_DEPTH >= 2");
      end
   end

   // ************************************************************
   // pin synchronisers and edge detection
   // ************************************************************
   logic [1:0] sclk_sync_q;
   logic [1:0] cs_n_sync_q;
   logic [1:0] si_sync_q;
   logic       sclk_prev_q;
   logic       sclk_s;
   logic       cs_n_s;
   logic       si_s;
   logic       rise;
   logic       fall;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sclk_sync_q <= 2'h0;
         cs_n_sync_q <= 2'h3;
         si_sync_q   <= 2'h0;
         sclk_prev_q <= 1'h0;
      end else begin
         sclk_sync_q <= {sclk_sync_q[0], sclk_i};
         cs_n_sync_q <= {cs_n_sync_q[0], cs_n_i};
         si_sync_q   <= {si_sync_q[0], si_i};
         sclk_prev_q <= sclk_sync_q[1];
      end
   end

   assign sclk_s = sclk_sync_q[1];
   assign cs_n_s = cs_n_sync_q[1];
   assign si_s   = si_sync_q[1];
   assign rise   = ~cs_n_s & sclk_s & ~sclk_prev_q;
   assign fall   = ~cs_n_s & ~sclk_s & sclk_prev_q;

   // ************************************************************
   // command sequencer
   // ************************************************************
   uisr_pkg::uisr_state_t state_q;
   uisr_pkg::uisr_mode_t  mode_q;
   logic [5:0]            bit_cnt_q;
   logic [23:0]           in_sh_q;
   logic [7:0]            cmd_byte;
   logic [23:0]           addr_word;
   logic [5:0]            dummy_last;
   logic                  cmd_done;
   logic                  addr_done;

   assign cmd_byte   = {in_sh_q[6:0], si_s};
   assign addr_word  = {in_sh_q[22:0], si_s};
   assign dummy_last = (mode_q == uisr_pkg::UISR_MODE_UID) ? `UISR_UID_DUMMY_BITS - 6'h01
                                                           : `UISR_TBL_DUMMY_BITS - 6'h01;
   assign cmd_done   = rise && state_q == uisr_pkg::UISR_ST_CMD && bit_cnt_q == `UISR_CMD_BITS - 6'h01;
   assign addr_done  = rise && state_q == uisr_pkg::UISR_ST_ADDR && bit_cnt_q == `UISR_ADDR_BITS - 6'h01;

   // inputs are taken on rising clock edges only
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || cs_n_s) begin
         in_sh_q <= 24'h000000;
      end else if (rise) begin
         in_sh_q <= addr_word;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || cs_n_s) begin
         state_q   <= uisr_pkg::UISR_ST_CMD;
         mode_q    <= uisr_pkg::UISR_MODE_TABLE;
         bit_cnt_q <= 6'h00;
      end else if (rise) begin
         bit_cnt_q <= bit_cnt_q + 6'h01;
         unique case (state_q)
            uisr_pkg::UISR_ST_CMD: begin
               if (cmd_done) begin
                  bit_cnt_q <= 6'h00;
                  if (cmd_byte == `UISR_OP_UNIQUE_NUMBER_READ) begin
                     mode_q  <= uisr_pkg::UISR_MODE_UID;
                     state_q <= uisr_pkg::UISR_ST_DUMMY;
                  end else if (cmd_byte == `UISR_OP_PARAM_TABLE_READ && !busy_i) begin
                     mode_q  <= uisr_pkg::UISR_MODE_TABLE;
                     state_q <= uisr_pkg::UISR_ST_ADDR;
                  end else begin
                     state_q <= uisr_pkg::UISR_ST_IGNORE;
                  end
               end
            end
            uisr_pkg::UISR_ST_ADDR: begin
               if (addr_done) begin
                  bit_cnt_q <= 6'h00;
                  state_q   <= uisr_pkg::UISR_ST_DUMMY;
               end
            end
            uisr_pkg::UISR_ST_DUMMY: begin
               if (bit_cnt_q == dummy_last) begin
                  bit_cnt_q <= 6'h00;
                  state_q   <= uisr_pkg::UISR_ST_DATA;
               end
            end
            uisr_pkg::UISR_ST_DATA: begin
               bit_cnt_q <= 6'h00;
            end
            uisr_pkg::UISR_ST_IGNORE: begin
               bit_cnt_q <= 6'h00;
            end
            default: begin
               state_q <= uisr_pkg::UISR_ST_IGNORE;
            end
         endcase
      end
   end

   // ************************************************************
   // byte fetch into the fifo, running ahead of the shifter
   // ************************************************************
   logic [TBL_AW-1:0] fetch_idx_q;
   logic              fetch_en_q;
   logic              pend_q;
   logic [7:0]        uid_byte_q;
   logic [127:0]      uid_sh;
   logic              uid_done;
   logic              issue;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              fifo_out_ready;
   logic [7:0]        fifo_out_data;
   logic [7:0]        rom_data;
   logic [7:0]        push_data;

   // the number is a build-time constant; no path writes it
   assign uid_sh    = UNIQUE_ID << {fetch_idx_q[3:0], 3'h0};
   assign uid_done  = mode_q == uisr_pkg::UISR_MODE_UID && 8'(fetch_idx_q) == `UISR_UID_BYTES;
   assign issue     = fetch_en_q & ~pend_q & fifo_in_ready & ~uid_done & ~cs_n_s;
   assign push_data = (mode_q == uisr_pkg::UISR_MODE_UID) ? uid_byte_q : rom_data;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || cs_n_s) begin
         fetch_en_q  <= 1'h0;
         fetch_idx_q <= '0;
      end else if (cmd_done && cmd_byte == `UISR_OP_UNIQUE_NUMBER_READ) begin
         fetch_en_q  <= 1'h1;
         fetch_idx_q <= '0;
      end else if (addr_done) begin
         fetch_en_q  <= 1'h1;
         fetch_idx_q <= addr_word[TBL_AW-1:0];
      end else if (issue) begin
         fetch_idx_q <= fetch_idx_q + 1'h1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || cs_n_s) begin
         pend_q     <= 1'h0;
         uid_byte_q <= 8'h00;
      end else begin
         pend_q <= issue;
         if (issue) begin
            uid_byte_q <= uid_sh[127:120];
         end
      end
   end

   uisr_rom #(
      .AW        (TBL_AW),
      .VENDOR_ID (VENDOR_ID)
   ) u_rom (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .rd_en_i   (issue),
      .rd_addr_i (fetch_idx_q),
      .rd_data_o (rom_data)
   );

   uisr_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .flush_i     (cs_n_s),
      .in_valid_i  (pend_q),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (push_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out_data)
   );

   // ************************************************************
   // output shifter, changes on falling clock edges
   // ************************************************************
   logic [7:0] out_sh_q;
   logic [2:0] out_bit_q;
   logic       data_fall;
   logic       load;

   assign data_fall      = fall && state_q == uisr_pkg::UISR_ST_DATA;
   assign load           = data_fall && out_bit_q == 3'h0;
   assign fifo_out_ready = load;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || cs_n_s) begin
         so_o      <= `UISR_IDLE_FILL;
         so_oe_o   <= 1'h0;
         out_sh_q  <= 8'h00;
         out_bit_q <= 3'h0;
      end else if (data_fall) begin
         so_oe_o <= 1'h1;
         if (load) begin
            out_bit_q <= 3'h7;
            if (fifo_out_valid) begin
               so_o     <= fifo_out_data[7];
               out_sh_q <= {fifo_out_data[6:0], 1'h0};
            end else begin
               so_o     <= `UISR_IDLE_FILL;
               out_sh_q <= {8{`UISR_IDLE_FILL}};
            end
         end else begin
            out_bit_q <= out_bit_q - 3'h1;
            so_o      <= out_sh_q[7];
            out_sh_q  <= {out_sh_q[6:0], 1'h0};
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   sequence seq_last_dummy;
      rise && state_q == uisr_pkg::UISR_ST_DUMMY && bit_cnt_q == dummy_last;
   endsequence

   sequence seq_table_cmd;
      cmd_done && cmd_byte == `UISR_OP_PARAM_TABLE_READ;
   endsequence

   AST_DESELECT_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cs_n_s |=> !so_oe_o && state_q == uisr_pkg::UISR_ST_CMD)
      else $error("output still driven after deselect");
   AST_TABLE_DECODE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      seq_table_cmd ##0 !busy_i |=> state_q == uisr_pkg::UISR_ST_ADDR)
      else $error("table read not decoded");
   AST_BUSY_REJECT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      seq_table_cmd ##0 busy_i |=> state_q == uisr_pkg::UISR_ST_IGNORE [*2])
      else $error("table read accepted while busy");
   AST_UID_DUMMY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cmd_done && cmd_byte == `UISR_OP_UNIQUE_NUMBER_READ
      |=> state_q == uisr_pkg::UISR_ST_DUMMY && dummy_last == `UISR_UID_DUMMY_BITS - 6'h01)
      else $error("unique read dummy length wrong");
   AST_DATA_AFTER_DUMMY: assert property (@(posedge sys_clk_i) disable iff (rst_i || cs_n_s)
      seq_last_dummy |=> state_q == uisr_pkg::UISR_ST_DATA)
      else $error("no data phase after dummy bits");
   AST_START_ADDR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      addr_done |=> fetch_idx_q == $past(addr_word[TBL_AW-1:0]))
      else $error("start address not loaded");
   AST_ADDR_STEP: assert property (@(posedge sys_clk_i) disable iff (rst_i || cs_n_s)
      issue |=> fetch_idx_q == TBL_AW'($past(fetch_idx_q) + 1'h1) && pend_q)
      else $error("table address did not advance by one");
   AST_MSB_FIRST: assert property (@(posedge sys_clk_i) disable iff (rst_i || cs_n_s)
      load && fifo_out_valid |=> so_o == $past(fifo_out_data[7]) && out_bit_q == 3'h7)
      else $error("byte not sent msb first");
   AST_SHIFT_ON_FALL: assert property (@(posedge sys_clk_i) disable iff (rst_i || cs_n_s)
      !data_fall && so_oe_o |=> $stable(so_o))
      else $error("output changed away from a falling edge");
   AST_NO_OVERFLOW: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pend_q |-> fifo_in_ready)
      else $error("fetch pushed into a full fifo");
endmodule // uisr_top
`default_nettype wire

// >>> tb/uisr_host.sv
// host serial controller model driving select, clock and data
`timescale 1ns/1ns
`default_nettype none
module uisr_host (
   // clock
   input  wire logic sys_clk_i,
   // serial pins
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      si_o,
   input  wire logic so_i
);
   initial begin
      cs_n_o = 1'h1;
      sclk_o = 1'h0;
      si_o   = 1'h0;
   end
   // ********************
   // frame and byte tasks
   // ********************
   task automatic sel;
      repeat (6) @(posedge sys_clk_i);
      cs_n_o <= 1'h0;
      repeat (6) @(posedge sys_clk_i);
   endtask
   task automatic desel;
      repeat (6) @(posedge sys_clk_i);
      cs_n_o <= 1'h1;
      repeat (6) @(posedge sys_clk_i);
   endtask
   // clock rests low outside frames; half periods of 6/7 and 6 clocks average 125 ns
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si_o <= tx[i];
         repeat (6 + i % 2) @(posedge sys_clk_i);
         rx[i] = so_i;
         sclk_o <= 1'h1;
         repeat (6) @(posedge sys_clk_i);
         sclk_o <= 1'h0;
      end
   endtask
endmodule // uisr_host
`default_nettype wire

// >>> tb/test_unique_id_and_sfdp_read.sv
// self-checking bench for the unique-number and parameter-table read front end
`timescale 1ns/1ns
`default_nettype none
module test_unique_id_and_sfdp_read;
   // arbitrary stand-in values
   localparam logic [127:0] UID = 128'hA5C3_0F1E_2D3C_4B5A_6978_8796_B4C2_D1E0;
   localparam logic [7:0]   VID = 8'h3E;
   localparam logic [191:0] TBL = {8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
      8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, VID, 8'h00, 8'h01, 8'h03,
      8'h60, 8'h00, 8'h00, 8'hFF};
   logic       sys_clk;
   logic       rst;
   logic       cs_n;
   logic       sclk;
   logic       si;
   logic       so;
   logic       so_oe;
   logic       busy;
   // no pull-up on the output line: an undriven line reads as the inverse of the last value
   logic       so_pin;
   assign so_pin = so_oe ? so : ~so;
   logic [7:0] rx;
   int         fails = 0;
   int         cmp_count = 0;
   initial sys_clk = 1'h0;
   always #5 sys_clk = ~sys_clk;
   uisr_top #(.UNIQUE_ID(UID), .VENDOR_ID(VID)) uut (.sys_clk_i(sys_clk), .rst_i(rst), .cs_n_i(cs_n),
      .sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_o(so_oe), .busy_i(busy));
   uisr_host host (.sys_clk_i(sys_clk), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so_pin));
   // ********************
   // scenarios
   // ********************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tbl_open(input logic [23:0] a);
      host.sel();
      host.xfer(8'h5A, rx);
      for (int k = 2; k >= 0; k--) host.xfer(a[8*k +: 8], rx);
      host.xfer(8'h00, rx);
   endtask
   task automatic uid_open;
      host.sel();
      host.xfer(8'h4B, rx);
      repeat (4) host.xfer(8'h00, rx);
   endtask
   task automatic sc_uid;
      uid_open();
      for (int k = 15; k >= 0; k--) begin
         host.xfer(8'h00, rx);
         chk(rx, UID[8*k +: 8]);
      end
      host.xfer(8'h00, rx);
      chk(rx, 8'hFF);
      host.desel();
   endtask
   task automatic sc_header;
      tbl_open(24'h000000);
      for (int k = 0; k < 24; k++) begin
         host.xfer(8'h00, rx);
         chk(rx, TBL[191-8*k -: 8]);
      end
      host.desel();
   endtask
   // even start two bytes below the top, so the counter wraps mid-stream
   task automatic sc_wrap;
      tbl_open(24'h00007E);
      for (int k = 0; k < 5; k++) begin
         host.xfer(8'h00, rx);
         chk(rx, (k < 2) ? 8'hFF : TBL[191-8*(k-2) -: 8]);
      end
      host.desel();
   endtask
   task automatic sc_abort;
      tbl_open(24'h000005);
      host.xfer(8'h00, rx);
      chk(rx, 8'h01);
      chk({7'h00, so_oe}, 8'h01);
      host.desel();
      chk({7'h00, so_oe}, 8'h00);
   endtask
   task automatic sc_busy;
      busy <= 1'h1;
      tbl_open(24'h000000);
      host.xfer(8'h00, rx);
      chk(rx, 8'h00);
      chk({7'h00, so_oe}, 8'h00);
      host.desel();
      // busy holds back only the table read, not the unique-number read
      uid_open();
      host.xfer(8'h00, rx);
      chk(rx, UID[127:120]);
      host.desel();
      busy <= 1'h0;
   endtask
   initial begin
      rst = 1'h1;
      busy = 1'h0;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      repeat (3) @(posedge sys_clk);
      sc_uid();
      sc_header();
      sc_wrap();
      sc_abort();
      sc_busy();
      sc_header();
      end_sim();
   end
   initial begin
      repeat (50000) @(posedge sys_clk);
      fails++;
      end_sim();
   end
endmodule // test_unique_id_and_sfdp_read
`default_nettype wire
